/* lass_pkg.sv */
package lass_pkg;
   localparam int          ADDR_W        = 6;
   localparam int          DATA_W        = 32;
   localparam int          VEL_W         = 23;
   localparam int          PW_W          = 10;
   localparam int          LOAD_W        = 9;
   localparam int          THR_W         = 8;

   localparam logic [5:0]  OFS_CTRL      = 6'h00;
   localparam logic [5:0]  OFS_CHOP      = 6'h04;
   localparam logic [5:0]  OFS_MIN_VEL   = 6'h08;
   localparam logic [5:0]  OFS_DET_VEL   = 6'h0C;
   localparam logic [5:0]  OFS_PW        = 6'h10;
   localparam logic [5:0]  OFS_STALL_THR = 6'h14;
   localparam logic [5:0]  OFS_RSTAT     = 6'h18;
   localparam logic [5:0]  OFS_RCV       = 6'h1C;
   localparam logic [5:0]  OFS_LOAD      = 6'h20;
   localparam logic [5:0]  OFS_POS       = 6'h24;
   localparam logic [5:0]  OFS_INT_STAT  = 6'h28;
   localparam logic [5:0]  OFS_INT_MASK  = 6'h2C;

   localparam int          CTRL_STOP_BIT = 0;
   localparam int          CHOP_CHOPPER_OFF_TIME_LSB = 0;
   localparam int          CHOP_TBL_LSB  = 4;
   localparam int          CHOP_FS_BIT   = 6;
   localparam int          CHOP_CHM_BIT  = 7;
   localparam int          CHOP_QUIET_BIT = 8;
   localparam int          RSTAT_STOP_BIT = 0;
   localparam int          RSTAT_LOAD_BIT = 1;
   localparam int          RSTAT_SLOW_BIT = 2;
   localparam int          INT_STALL_BIT = 0;
   localparam int          INT_LOAD_BIT  = 1;

   localparam logic [3:0]  CHOPPER_OFF_TIME_CAP      = 4'h8;
   localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
   localparam logic [31:0] CHOP_RST      = 32'h0000_0003;
   localparam logic [31:0] MIN_VEL_RST   = 32'h0000_0000;
   localparam logic [31:0] DET_VEL_RST   = 32'h0000_0000;
   localparam logic [31:0] PW_RST        = 32'h0000_0000;
   localparam logic [31:0] THR_RST       = 32'h0000_0000;
   localparam logic [31:0] INT_RST       = 32'h0000_0000;

   typedef enum logic [1:0] {LASS_RUN = 2'b01, LASS_STOP = 2'b10} lass_stop_e;
   typedef enum logic [1:0] {LASS_M_IDLE = 2'b01, LASS_M_MEAS = 2'b10} lass_meas_e;

   function automatic logic [31:0] apply_be(input logic [31:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : apply_be
endpackage : lass_pkg

/* lass_meter_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface lass_meter_if;
   logic       start;
   logic [9:0] pulse_width;
   logic       sense;
   logic       done;
   logic       late;
   logic [8:0] load_value;
   modport ctrl  (output start, output pulse_width, output sense, input done, input late, input load_value);
   modport meter (input start, input pulse_width, input sense, output done, output late, output load_value);
endinterface : lass_meter_if
`default_nettype wire

/* lass_load_meter.sv */
`timescale 1ns/1ps
`default_nettype none
module lass_load_meter (
   input wire logic    clk,
   input wire logic    rst,
   lass_meter_if.meter mif
);
   lass_pkg::lass_meas_e st_reg, st_next;
   logic [9:0]           elapsed_reg, elapsed_next;
   logic [8:0]           load_reg, load_next;
   logic                 done_reg, done_next;
   logic                 late_reg, late_next;
   logic [9:0]           margin;

   always_comb begin
      st_next      = st_reg;
      elapsed_next = elapsed_reg;
      load_next    = load_reg;
      done_next    = 1'b0;
      late_next    = late_reg;
      margin       = mif.pulse_width - elapsed_reg;
      case (st_reg)
         lass_pkg::LASS_M_IDLE: begin
            if (mif.start) begin
               elapsed_next = 10'h000;
               st_next      = lass_pkg::LASS_M_MEAS;
            end
         end
         lass_pkg::LASS_M_MEAS: begin
            // Margin left in the reference window, halved so it fits 0..511
            if (mif.sense) begin
               load_next = margin[9:1];
               late_next = 1'b0;
               done_next = 1'b1;
               st_next   = lass_pkg::LASS_M_IDLE;
            end else if (elapsed_reg >= mif.pulse_width) begin
               load_next = 9'h000;
               late_next = 1'b1;
               done_next = 1'b1;
               st_next   = lass_pkg::LASS_M_IDLE;
            end else begin
               elapsed_next = elapsed_reg + 10'h001;
            end
         end
         default: st_next = lass_pkg::LASS_M_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg      <= lass_pkg::LASS_M_IDLE;
         elapsed_reg <= 10'h000;
         load_reg    <= 9'h000;
         done_reg    <= 1'b0;
         late_reg    <= 1'b0;
      end else begin
         st_reg      <= st_next;
         elapsed_reg <= elapsed_next;
         load_reg    <= load_next;
         done_reg    <= done_next;
         late_reg    <= late_next;
      end
   end

   assign mif.done       = done_reg;
   assign mif.late       = late_reg;
   assign mif.load_value = load_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_late_zero_load: assert property (done_reg && late_reg |-> load_reg == 9'h000)
      else $error("late measurement did not report zero load");
   a_window_bound: assert property (st_reg == lass_pkg::LASS_M_MEAS && !mif.sense
                                    && elapsed_reg >= mif.pulse_width |=> done_reg && late_reg)
      else $error("window end not reported as late");
endmodule : lass_load_meter
`default_nettype wire

/* lass_stall_stop.sv */
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lass_stall_stop (
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic [5:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   input  wire logic [22:0] RAMP_TARGET_VELOCITY,
   input  wire logic [31:0] POSITION,
   input  wire logic        FULLSTEP_START,
   input  wire logic        MOTOR_STEP_SENSE,
   output logic      [22:0] COMMUTATION_VELOCITY,
   output logic             FULLSTEP_MODE,
   output logic      [3:0]  OFF_TIME,
   output logic      [1:0]  BLANK_TIME,
   output logic             RAMP_HOLD,
   output logic             IRQ
);
   lass_meter_if mif ();

   logic [31:0] ctrl_reg, ctrl_next;
   logic [31:0] chop_reg, chop_next;
   logic [31:0] minv_reg, minv_next;
   logic [31:0] detv_reg, detv_next;
   logic [31:0] pw_reg, pw_next;
   logic [31:0] thr_reg, thr_next;
   logic [31:0] ist_reg, ist_next;
   logic [31:0] imask_reg, imask_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        ack_reg, ack_next;
   logic        sense_meta_reg, sense_sync_reg;
   lass_pkg::lass_stop_e stop_reg, stop_next;
   logic        load_reg, load_next;
   logic        slow_reg, slow_next;
   logic [22:0] cvel_reg, cvel_next;
   logic [3:0]  chopper_off_time_reg, chopper_off_time_next;
   logic [22:0] min_vel, det_vel, rcv;
   logic [3:0]  chopper_off_time_field;
   logic        req, wr_acc, rd_acc, rd_first, rstat_read, stall_det, stopped;
   logic [31:0] rstat_word, rd_mux;

   assign min_vel    = minv_reg[22:0];
   assign det_vel    = detv_reg[22:0];
   assign chopper_off_time_field = chop_reg[lass_pkg::CHOP_CHOPPER_OFF_TIME_LSB +: 4];
   assign stopped    = (stop_reg == lass_pkg::LASS_STOP);

   // Bus: one wait cycle per access, read data captured in that cycle
   assign req        = AVS_READ | AVS_WRITE;
   assign rd_first   = AVS_READ & ~ack_reg;
   assign wr_acc     = AVS_WRITE & ack_reg;
   assign rd_acc     = AVS_READ & ack_reg;
   assign rstat_read = rd_acc && (AVS_ADDRESS == lass_pkg::OFS_RSTAT);
   assign AVS_WAITREQUEST = req & ~ack_reg;

   // Pin from the power stage is asynchronous
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         sense_meta_reg <= 1'b0;
         sense_sync_reg <= 1'b0;
      end else begin
         sense_meta_reg <= MOTOR_STEP_SENSE;
         sense_sync_reg <= sense_meta_reg;
      end
   end

   assign mif.start       = FULLSTEP_START & load_reg;
   assign mif.pulse_width = pw_reg[9:0];
   assign mif.sense       = sense_sync_reg;

   lass_load_meter u_meter (
      .clk (CLK),
      .rst (SYS_RST),
      .mif (mif)
   );

   // Detection only at or below the host's detect threshold
   assign stall_det = mif.done && load_reg && (RAMP_TARGET_VELOCITY <= det_vel)
                      && ({1'b0, thr_reg[7:0]} > mif.load_value);

   assign rcv = stopped ? 23'h000000 : RAMP_TARGET_VELOCITY;

   always_comb begin
      rstat_word = 32'h0000_0000;
      rstat_word[lass_pkg::RSTAT_STOP_BIT] = stopped;
      rstat_word[lass_pkg::RSTAT_LOAD_BIT] = load_reg;
      rstat_word[lass_pkg::RSTAT_SLOW_BIT] = slow_reg;
      case (AVS_ADDRESS)
         lass_pkg::OFS_CTRL:      rd_mux = ctrl_reg;
         lass_pkg::OFS_CHOP:      rd_mux = chop_reg;
         lass_pkg::OFS_MIN_VEL:   rd_mux = minv_reg;
         lass_pkg::OFS_DET_VEL:   rd_mux = detv_reg;
         lass_pkg::OFS_PW:        rd_mux = pw_reg;
         lass_pkg::OFS_STALL_THR: rd_mux = thr_reg;
         lass_pkg::OFS_RSTAT:     rd_mux = rstat_word;
         lass_pkg::OFS_RCV:       rd_mux = {9'h000, rcv};
         lass_pkg::OFS_LOAD:      rd_mux = {23'h000000, mif.load_value};
         lass_pkg::OFS_POS:       rd_mux = POSITION;
         lass_pkg::OFS_INT_STAT:  rd_mux = ist_reg;
         lass_pkg::OFS_INT_MASK:  rd_mux = imask_reg;
         default:                 rd_mux = 32'h0000_0000;
      endcase
   end

   always_comb begin
      ack_next   = req & ~ack_reg;
      rdata_next = rd_first ? rd_mux : rdata_reg;
      ctrl_next  = ctrl_reg;
      chop_next  = chop_reg;
      minv_next  = minv_reg;
      detv_next  = detv_reg;
      pw_next    = pw_reg;
      thr_next   = thr_reg;
      imask_next = imask_reg;
      ist_next   = ist_reg;
      if (wr_acc) begin
         case (AVS_ADDRESS)
            lass_pkg::OFS_CTRL:      ctrl_next  = lass_pkg::apply_be(ctrl_reg, AVS_WRITEDATA, AVS_BYTEENABLE) & 32'h0000_0001;
            lass_pkg::OFS_CHOP:      chop_next  = lass_pkg::apply_be(chop_reg, AVS_WRITEDATA, AVS_BYTEENABLE) & 32'h0000_01FF;
            lass_pkg::OFS_MIN_VEL:   minv_next  = lass_pkg::apply_be(minv_reg, AVS_WRITEDATA, AVS_BYTEENABLE) & 32'h007F_FFFF;
            lass_pkg::OFS_DET_VEL:   detv_next  = lass_pkg::apply_be(detv_reg, AVS_WRITEDATA, AVS_BYTEENABLE) & 32'h007F_FFFF;
            lass_pkg::OFS_PW:        pw_next    = lass_pkg::apply_be(pw_reg, AVS_WRITEDATA, AVS_BYTEENABLE) & 32'h0000_03FF;
            lass_pkg::OFS_STALL_THR: thr_next   = lass_pkg::apply_be(thr_reg, AVS_WRITEDATA, AVS_BYTEENABLE) & 32'h0000_00FF;
            lass_pkg::OFS_INT_MASK:  imask_next = lass_pkg::apply_be(imask_reg, AVS_WRITEDATA, AVS_BYTEENABLE) & 32'h0000_0003;
            lass_pkg::OFS_INT_STAT:  ist_next   = ist_reg & ~(AVS_WRITEDATA & {{8{AVS_BYTEENABLE[3]}},
                                                  {8{AVS_BYTEENABLE[2]}}, {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}});
            default: ;
         endcase
      end
      // Set after clear so a same-cycle event survives
      if (!stopped && stop_next == lass_pkg::LASS_STOP) begin
         ist_next[lass_pkg::INT_STALL_BIT] = 1'b1;
      end
      if (!load_reg && load_next) begin
         ist_next[lass_pkg::INT_LOAD_BIT] = 1'b1;
      end
   end

   always_comb begin
      // Mode needs both chopper flags, a nonzero floor and no quiet chopper
      load_next = (min_vel != 23'h000000)
                  && chop_reg[lass_pkg::CHOP_FS_BIT] && chop_reg[lass_pkg::CHOP_CHM_BIT]
                  && !chop_reg[lass_pkg::CHOP_QUIET_BIT]
                  && (RAMP_TARGET_VELOCITY > min_vel);
      stop_next = stop_reg;
      case (stop_reg)
         lass_pkg::LASS_RUN: begin
            if (ctrl_reg[lass_pkg::CTRL_STOP_BIT] && stall_det) begin
               stop_next = lass_pkg::LASS_STOP;
            end
         end
         lass_pkg::LASS_STOP: begin
            // A fresh stall in the release cycle keeps the stop
            if (rstat_read && !(ctrl_reg[lass_pkg::CTRL_STOP_BIT] && stall_det)) begin
               stop_next = lass_pkg::LASS_RUN;
            end
         end
         default: stop_next = lass_pkg::LASS_RUN;
      endcase
      slow_next = slow_reg;
      if (!load_next) begin
         slow_next = 1'b0;
      end else if (mif.done) begin
         slow_next = mif.late;
      end
      // Overload drops commutation to the floor; a stall stop forces it to zero
      if (stopped) begin
         cvel_next = 23'h000000;
      end else if (load_next && slow_reg) begin
         cvel_next = min_vel;
      end else begin
         cvel_next = RAMP_TARGET_VELOCITY;
      end
      chopper_off_time_next = (load_next && chopper_off_time_field > lass_pkg::CHOPPER_OFF_TIME_CAP) ? lass_pkg::CHOPPER_OFF_TIME_CAP : chopper_off_time_field;
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ctrl_reg  <= lass_pkg::CTRL_RST;
         chop_reg  <= lass_pkg::CHOP_RST;
         minv_reg  <= lass_pkg::MIN_VEL_RST;
         detv_reg  <= lass_pkg::DET_VEL_RST;
         pw_reg    <= lass_pkg::PW_RST;
         thr_reg   <= lass_pkg::THR_RST;
         ist_reg   <= lass_pkg::INT_RST;
         imask_reg <= lass_pkg::INT_RST;
         rdata_reg <= 32'h0000_0000;
         ack_reg   <= 1'b0;
         stop_reg  <= lass_pkg::LASS_RUN;
         load_reg  <= 1'b0;
         slow_reg  <= 1'b0;
         cvel_reg  <= 23'h000000;
         chopper_off_time_reg  <= 4'h0;
      end else begin
         ctrl_reg  <= ctrl_next;
         chop_reg  <= chop_next;
         minv_reg  <= minv_next;
         detv_reg  <= detv_next;
         pw_reg    <= pw_next;
         thr_reg   <= thr_next;
         ist_reg   <= ist_next;
         imask_reg <= imask_next;
         rdata_reg <= rdata_next;
         ack_reg   <= ack_next;
         stop_reg  <= stop_next;
         load_reg  <= load_next;
         slow_reg  <= slow_next;
         cvel_reg  <= cvel_next;
         chopper_off_time_reg  <= chopper_off_time_next;
      end
   end

   assign AVS_READDATA         = rdata_reg;
   assign COMMUTATION_VELOCITY = cvel_reg;
   assign FULLSTEP_MODE        = load_reg;
   assign OFF_TIME             = chopper_off_time_reg;
   assign BLANK_TIME           = chop_reg[lass_pkg::CHOP_TBL_LSB +: 2];
   assign RAMP_HOLD            = stopped;
   assign IRQ                  = |(ist_reg & imask_reg);

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   a_stop_zero_vel: assert property (stopped |=> COMMUTATION_VELOCITY == 23'h000000)
      else $error("velocity not zero while stall-stopped");
   a_stall_enters_stop: assert property (!stopped && ctrl_reg[0] && stall_det |=> stopped && RAMP_HOLD)
      else $error("stall did not latch the stop");
   a_stop_held: assert property (stopped && !rstat_read |=> stopped)
      else $error("stop released without status read");
   a_release_on_read: assert property (stopped && rstat_read && !stall_det |=> !stopped ##0 !RAMP_HOLD)
      else $error("status read did not release the stop");
   a_flag_reads_stop: assert property (rd_first && AVS_ADDRESS == lass_pkg::OFS_RSTAT && stopped
                                       |=> AVS_READDATA[0] && !AVS_WAITREQUEST)
      else $error("stop flag missing from ramp status");
   a_fullstep_switch: assert property (load_next |=> FULLSTEP_MODE)
      else $error("fullstep not entered above floor velocity");
   a_off_time_cap: assert property (load_next && chopper_off_time_field >= 4'h8 |=> OFF_TIME == 4'h8)
      else $error("off time not capped in load mode");
   a_zero_floor_off: assert property (min_vel == 23'h000000 |=> !FULLSTEP_MODE)
      else $error("zero floor velocity left load mode on");
   a_floor_velocity: assert property (load_next && !stopped |=> COMMUTATION_VELOCITY >= $past(min_vel))
      else $error("commutation below floor velocity");
   a_quiet_blocks: assert property (chop_reg[8] |=> !FULLSTEP_MODE)
      else $error("quiet chopper did not block load mode");
   a_target_report: assert property (rd_first && AVS_ADDRESS == lass_pkg::OFS_RCV && !stopped
                                     |=> AVS_READDATA == {9'h000, $past(RAMP_TARGET_VELOCITY)})
      else $error("reported velocity differs from ramp target");
   a_sensitivity: assert property (mif.done && load_reg && !stopped && ctrl_reg[0]
                                   && RAMP_TARGET_VELOCITY <= det_vel
                                   && {1'b0, thr_reg[7:0]} > mif.load_value |=> stopped)
      else $error("load under threshold not treated as stall");

   c_stall_stop: cover property (!stopped ##1 stopped);
   c_release: cover property (stopped ##1 !stopped);
   c_slowdown: cover property (load_reg && slow_reg);
   c_irq: cover property (IRQ);
endmodule : lass_stall_stop
`default_nettype wire

/* lass_stall_stop_dummy_note.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* lass_motor_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Power stage stand-in: confirms a step some cycles after each fullstep start while not blocked
module lass_motor_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       start,
   input  wire logic       blocked,
   input  wire logic [7:0] delay,
   output logic            sense
);
   logic [8:0] cnt_reg;
   logic [8:0] cnt_next;
   always_comb begin
      cnt_next = cnt_reg;
      if (start) begin
         // A blocked rotor never confirms its step
         cnt_next = blocked ? 9'h000 : 9'h001;
      end else if (cnt_reg != 9'h000 && cnt_reg != 9'h1FF) begin
         cnt_next = cnt_reg + 9'h001;
      end
   end
   always_ff @(posedge clk) begin
      cnt_reg <= rst ? 9'h000 : cnt_next;
   end
   // Sense drops again after a short confirm pulse
   assign sense = (cnt_reg != 9'h000) && (cnt_reg >= {1'b0, delay}) && (cnt_reg < {1'b0, delay} + 9'h004);
endmodule : lass_motor_model
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk;
   logic        rst;
   logic        rd_en;
   logic        wr_en;
   logic        fs_start;
   logic        blocked;
   logic        sense;
   logic        wait_req;
   logic        fs_mode;
   logic        hold;
   logic        irq;
   logic [5:0]  addr;
   logic [3:0]  be;
   logic [3:0]  off_t;
   logic [1:0]  blank;
   logic [7:0]  dly;
   logic [22:0] target;
   logic [22:0] cvel;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [31:0] pos;
   logic [31:0] v1;
   logic [31:0] v2;
   int          n_fail;
   int          n_checks;

   lass_stall_stop u_dut (.CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd_en), .AVS_WRITE(wr_en),
      .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
      .RAMP_TARGET_VELOCITY(target), .POSITION(pos), .FULLSTEP_START(fs_start), .MOTOR_STEP_SENSE(sense),
      .COMMUTATION_VELOCITY(cvel), .FULLSTEP_MODE(fs_mode), .OFF_TIME(off_t), .BLANK_TIME(blank),
      .RAMP_HOLD(hold), .IRQ(irq));
   lass_motor_model u_motor (.clk(clk), .rst(rst), .start(fs_start), .blocked(blocked), .delay(dly),
      .sense(sense));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wait_ack();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (wait_req !== 1'b0 && k < 50);
      // A slave that never answers counts against the run
      if (wait_req !== 1'b0) begin
         n_fail++;
      end
   endtask : wait_ack

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      wait_ack();
      wr_en <= 1'b0;
      // Let registered outputs take the new value
      repeat (2) @(posedge clk);
   endtask : wr

   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      wait_ack();
      d = rdata;
      rd_en <= 1'b0;
   endtask : rd

   task automatic pulse(input int n);
      @(posedge clk);
      fs_start <= 1'b1;
      @(posedge clk);
      fs_start <= 1'b0;
      repeat (n) @(posedge clk);
   endtask : pulse

   task automatic wrap_up();
      if (n_fail == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up

   initial begin
      #(25 * 20000);
      n_fail++;
      wrap_up();
   end

   initial begin
      rst = 1'b1; rd_en = 1'b0; wr_en = 1'b0; fs_start = 1'b0; blocked = 1'b0; addr = 6'h00; be = 4'hF;
      dly = 8'h0A; target = 23'h000000; wdata = 32'h0; pos = 32'h1234_5678;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(lass_pkg::OFS_CHOP, v1);
      chk("chop_reset", v1, lass_pkg::CHOP_RST);
      chk("off_time_reset", {28'h0, off_t}, 32'h0000_0003);
      rd(6'h30, v1);
      chk("unmapped", v1, 32'h0000_0000);
      rd(lass_pkg::OFS_POS, v1);
      chk("position", v1, 32'h1234_5678);
      wr(lass_pkg::OFS_DET_VEL, 32'h007F_FFFF);
      wr(lass_pkg::OFS_PW, 32'h0000_0064);
      wr(lass_pkg::OFS_INT_MASK, 32'h0000_0003);
      wr(lass_pkg::OFS_CHOP, 32'h0000_00E5);
      @(posedge clk);
      target <= 23'd1000;
      repeat (3) @(posedge clk);
      chk("fs_min_zero", {31'h0, fs_mode}, 32'h0);
      wr(lass_pkg::OFS_MIN_VEL, 32'h0000_0064);
      chk("fs_above_min", {31'h0, fs_mode}, 32'h1);
      chk("off_time", {28'h0, off_t}, 32'h5);
      chk("blank", {30'h0, blank}, 32'h2);
      target <= 23'd50;
      repeat (3) @(posedge clk);
      chk("fs_below_min", {31'h0, fs_mode}, 32'h0);
      target <= 23'd1000;
      wr(lass_pkg::OFS_CHOP, 32'h0000_00EF);
      chk("off_time_cap", {28'h0, off_t}, 32'h8);
      wr(lass_pkg::OFS_CHOP, 32'h0000_01E5);
      chk("fs_quiet", {31'h0, fs_mode}, 32'h0);
      wr(lass_pkg::OFS_CHOP, 32'h0000_00E5);
      rd(lass_pkg::OFS_RCV, v1);
      chk("rcv_target", v1, 32'd1000);
      pulse(120);
      rd(lass_pkg::OFS_LOAD, v1);
      wr(lass_pkg::OFS_PW, 32'h0000_00C8);
      pulse(220);
      rd(lass_pkg::OFS_LOAD, v2);
      chk("load_delta", v2 - v1, 32'd50);
      chk("load_range", {31'h0, v2 <= 32'd255}, 32'h1);
      wr(lass_pkg::OFS_PW, 32'h0000_0028);
      blocked <= 1'b1;
      pulse(60);
      chk("cvel_slow", {9'h0, cvel}, 32'd100);
      blocked <= 1'b0;
      pulse(60);
      chk("cvel_target", {9'h0, cvel}, 32'd1000);
      wr(lass_pkg::OFS_CTRL, 32'h0000_0001);
      blocked <= 1'b1;
      pulse(60);
      chk("no_stall_thr0", {31'h0, hold}, 32'h0);
      wr(lass_pkg::OFS_STALL_THR, 32'h0000_0003);
      pulse(60);
      chk("stall_hold", {31'h0, hold}, 32'h1);
      chk("stall_cvel", {9'h0, cvel}, 32'h0);
      chk("irq_set", {31'h0, irq}, 32'h1);
      rd(lass_pkg::OFS_RCV, v1);
      chk("rcv_stopped", v1, 32'h0);
      chk("hold_kept", {31'h0, hold}, 32'h1);
      rd(lass_pkg::OFS_RSTAT, v1);
      chk("stop_flag", v1 & 32'h1, 32'h1);
      repeat (3) @(posedge clk);
      chk("hold_released", {31'h0, hold}, 32'h0);
      rd(lass_pkg::OFS_RSTAT, v1);
      chk("stop_flag_clr", v1 & 32'h1, 32'h0);
      rd(lass_pkg::OFS_INT_STAT, v1);
      chk("int_stall", v1 & 32'h1, 32'h1);
      wr(lass_pkg::OFS_INT_MASK, 32'h0000_0000);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      wr(lass_pkg::OFS_INT_MASK, 32'h0000_0003);
      wr(lass_pkg::OFS_INT_STAT, 32'h0000_0003);
      chk("irq_cleared", {31'h0, irq}, 32'h0);
      wr(lass_pkg::OFS_RCV, 32'h0000_0005);
      rd(lass_pkg::OFS_RCV, v1);
      chk("rcv_readonly", v1, 32'd1000);
      wrap_up();
   end
endmodule : tb
`default_nettype wire
